//--- design/apll_cfg_regs.vh
`ifndef APLL_CFG_REGS_VH
`define APLL_CFG_REGS_VH

// Register byte addresses on the configuration port.
`define OFS_LOOP_FILTER 16'h00b0
`define OFS_MODE_LOCK 16'h00b1
`define OFS_VCO_SEL_CODE_A 16'h00b2
`define OFS_CODE_B 16'h00b3

// Implemented-bit masks; every other bit is reserved.
`define MASK_LOOP_FILTER 8'hff
`define MASK_MODE_LOCK 8'h0b
`define MASK_VCO_SEL_CODE_A 8'h3f
`define MASK_CODE_B 8'h1f

// Reset values of whole registers, reserved bits cleared.
`define RST_LOOP_FILTER 8'h8b
`define RST_MODE_LOCK 8'h02
`define RST_VCO_SEL_CODE_A 8'h2b
`define RST_CODE_B 8'h00

// Field positions in the loop filter register.
`define PUMP_MSB 7
`define PUMP_LSB 5
`define SRES_MSB 4
`define SRES_LSB 3
`define PCAP_MSB 2
`define PCAP_LSB 1
`define POLE_BIT 0

// Field positions in the mode and lock register.
`define SYNTH_BIT 3
`define ACCUR_BIT 1
`define OVRD_BIT 0

// Field positions in the two manual code registers.
`define CHOICE_BIT 5
`define CODE_MSB 4
`define CODE_LSB 0

// Companion digital loop state that means forced free-run.
`define STATE_FREERUN 2'h3

// Physical values of the analog settings.
`define PUMP_STEP_UA 10'h06e
`define PUMP_RST_UA 10'h226
`define SRES_OHM_0 11'h14a
`define SRES_OHM_1 11'h280
`define SRES_OHM_2 11'h4b0
`define SRES_OHM_3 11'h6fe
`define PCAP_PF_0 8'h28
`define PCAP_PF_1 8'h50
`define PCAP_PF_2 8'h8c
`define PCAP_PF_3 8'hc8
`define POST_OHM_0 11'h1f1
`define POST_OHM_1 11'h62c
`define POST_CAP_PF 8'h28
`define LOCK_PPM_0 5'h01
`define LOCK_PPM_1 5'h10

`endif

//--- design/cfg_byte_reg.v
`timescale 1ns/1ps
module cfg_byte_reg #(
  parameter [7:0] RESET_VAL = 8'h00,
  parameter [7:0] WR_MASK = 8'hff
) (
  // Clock, reset and freeze.
  input wire clk,
  input wire rst_n,
  input wire ce,
  // Write strobe and data.
  input wire wr_en,
  input wire [7:0] wdata,
  // Stored value.
  output reg [7:0] q
);

  // Reserved bits are never stored, so they read back as zero.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RESET_VAL;
    end else if (ce && wr_en) begin
      q <= wdata & WR_MASK;
    end
  end

endmodule

//--- design/loop_value_decode.v
`timescale 1ns/1ps
`include "apll_cfg_regs.vh"
module loop_value_decode (
  // Clock, reset and freeze.
  input wire clk,
  input wire rst_n,
  input wire ce,
  // Codes from the configuration bank.
  input wire [2:0] pump_code,
  input wire [1:0] sres_code,
  input wire [1:0] pcap_code,
  input wire pole_code,
  input wire accur_code,
  // Physical values for the analog trim logic.
  output reg [9:0] pump_current_ua_r,
  output reg [10:0] series_res_ohm_r,
  output reg [7:0] parallel_cap_pf_r,
  output reg [10:0] post_res_ohm_r,
  output reg [7:0] post_cap_pf_r,
  output reg [4:0] lock_ppm_r
);

  // Pump current rises in equal steps from one step upward.
  function [9:0] pump_ua;
    input [2:0] code;
    begin
      pump_ua = `PUMP_STEP_UA * ({7'h00, code} + 10'h001);
    end
  endfunction

  // Four-entry resistor table shared shape for series values.
  function [10:0] sres_ohm;
    input [1:0] code;
    begin
      case (code)
        2'h0: sres_ohm = `SRES_OHM_0;
        2'h1: sres_ohm = `SRES_OHM_1;
        2'h2: sres_ohm = `SRES_OHM_2;
        default: sres_ohm = `SRES_OHM_3;
      endcase
    end
  endfunction

  function [7:0] pcap_pf;
    input [1:0] code;
    begin
      case (code)
        2'h0: pcap_pf = `PCAP_PF_0;
        2'h1: pcap_pf = `PCAP_PF_1;
        2'h2: pcap_pf = `PCAP_PF_2;
        default: pcap_pf = `PCAP_PF_3;
      endcase
    end
  endfunction

  // Values follow the codes one cycle later.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pump_current_ua_r <= `PUMP_RST_UA;
      series_res_ohm_r <= `SRES_OHM_1;
      parallel_cap_pf_r <= `PCAP_PF_1;
      post_res_ohm_r <= `POST_OHM_1;
      post_cap_pf_r <= `POST_CAP_PF;
      lock_ppm_r <= `LOCK_PPM_1;
    end else if (ce) begin
      pump_current_ua_r <= pump_ua(pump_code);
      series_res_ohm_r <= sres_ohm(sres_code);
      parallel_cap_pf_r <= pcap_pf(pcap_code);
      post_res_ohm_r <= pole_code ? `POST_OHM_1 : `POST_OHM_0;
      post_cap_pf_r <= `POST_CAP_PF;
      lock_ppm_r <= accur_code ? `LOCK_PPM_1 : `LOCK_PPM_0;
    end
  end

endmodule

//--- design/analog_pll_config_bank.v
// What this block does
// - 3-bit pump current field, resets to 100b.
// - 2-bit series resistor field, resets to 01b.
// - 2-bit parallel capacitor field, resets to 01b.
// - Second-pole resistor select bit, resets to one.
// - Lock accuracy select bit, resets to one.
// - Lock override bit: automatic or manual, resets zero.
// - Manual oscillator choice bit, resets to one.
// - Manual code for oscillator A, resets 01011b.
// - Manual code for oscillator B, resets zero.
// - Synthesizer-only mode bit, resets to zero.
// - Reserved bits written zero, read back as zero.
`timescale 1ns/1ps
`include "apll_cfg_regs.vh"
module analog_pll_config_bank (
  // Clock, reset and freeze.
  input wire clk,
  input wire rst_n,
  input wire ce,
  // Byte register port from the serial configuration engine.
  input wire [15:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_r,
  output reg reg_rd_valid_r,
  output reg reg_hit_r,
  output reg rsvd_write_r,
  // Companion digital loop state, same clock.
  input wire [1:0] digital_loop_state,
  // Raw loop filter codes and the lock accuracy bit.
  output reg [2:0] pump_current_sel,
  output reg [1:0] filter_series_res_sel,
  output reg [1:0] filter_parallel_cap_sel,
  output reg second_pole_sel,
  output reg lock_accuracy_sel,
  // Lock and mode controls.
  output reg lock_override_sel,
  output reg manual_osc_choice,
  output reg [4:0] manual_code_osc_a,
  output reg [4:0] manual_code_osc_b,
  output reg synth_only_sel,
  // Effective manual lock drive.
  output reg manual_active_r,
  output reg osc_a_manual_r,
  output reg osc_b_manual_r,
  output reg [4:0] applied_code_r,
  // Free-run demand toward the companion loop.
  output reg freerun_demand_r,
  output reg freerun_mismatch_r,
  // Change pulses for the analog side.
  output reg loop_retune_r,
  output reg lock_restart_r,
  // Decoded physical values.
  output wire [9:0] pump_current_ua_r,
  output wire [10:0] series_res_ohm_r,
  output wire [7:0] parallel_cap_pf_r,
  output wire [10:0] post_res_ohm_r,
  output wire [7:0] post_cap_pf_r,
  output wire [4:0] lock_ppm_r
);

  wire [7:0] loop_q;
  wire [7:0] mode_q;
  wire [7:0] code_a_q;
  wire [7:0] code_b_q;
  reg wr_loop;
  reg wr_mode;
  reg wr_code_a;
  reg wr_code_b;
  reg [7:0] wr_mask;
  reg [7:0] wr_old;
  reg addr_hit;
  reg [7:0] rd_nxt;
  reg retune_nxt;
  reg restart_nxt;
  reg rsvd_nxt;
  reg [4:0] applied_nxt;

  // Whole-register defaults, so field resets slice the same constants
  // that the storage uses and cannot drift apart from them.
  localparam [7:0] LOOP_RST = `RST_LOOP_FILTER;
  localparam [7:0] MODE_RST = `RST_MODE_LOCK;
  localparam [7:0] CODE_A_RST = `RST_VCO_SEL_CODE_A;
  localparam [7:0] CODE_B_RST = `RST_CODE_B;

  // Address decode for writes; the mask tells which bits are real.
  always @* begin
    wr_loop = 1'b0;
    wr_mode = 1'b0;
    wr_code_a = 1'b0;
    wr_code_b = 1'b0;
    wr_mask = 8'h00;
    wr_old = 8'h00;
    addr_hit = 1'b1;
    if (reg_addr == `OFS_LOOP_FILTER) begin
      wr_loop = reg_wr;
      wr_mask = `MASK_LOOP_FILTER;
      wr_old = loop_q;
    end else if (reg_addr == `OFS_MODE_LOCK) begin
      wr_mode = reg_wr;
      wr_mask = `MASK_MODE_LOCK;
      wr_old = mode_q;
    end else if (reg_addr == `OFS_VCO_SEL_CODE_A) begin
      wr_code_a = reg_wr;
      wr_mask = `MASK_VCO_SEL_CODE_A;
      wr_old = code_a_q;
    end else if (reg_addr == `OFS_CODE_B) begin
      wr_code_b = reg_wr;
      wr_mask = `MASK_CODE_B;
      wr_old = code_b_q;
    end else begin
      addr_hit = 1'b0;
    end
  end

  // Storage; reserved bits are dropped on write and after reset.
  cfg_byte_reg #(
    .RESET_VAL(`RST_LOOP_FILTER),
    .WR_MASK(`MASK_LOOP_FILTER)
  ) u_loop_reg (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .wr_en(wr_loop),
    .wdata(reg_wdata),
    .q(loop_q)
  );

  cfg_byte_reg #(
    .RESET_VAL(`RST_MODE_LOCK),
    .WR_MASK(`MASK_MODE_LOCK)
  ) u_mode_reg (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .wr_en(wr_mode),
    .wdata(reg_wdata),
    .q(mode_q)
  );

  cfg_byte_reg #(
    .RESET_VAL(`RST_VCO_SEL_CODE_A),
    .WR_MASK(`MASK_VCO_SEL_CODE_A)
  ) u_code_a_reg (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .wr_en(wr_code_a),
    .wdata(reg_wdata),
    .q(code_a_q)
  );

  cfg_byte_reg #(
    .RESET_VAL(`RST_CODE_B),
    .WR_MASK(`MASK_CODE_B)
  ) u_code_b_reg (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .wr_en(wr_code_b),
    .wdata(reg_wdata),
    .q(code_b_q)
  );

  // Field views, re-registered so outputs stay clean flops.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pump_current_sel <= LOOP_RST[`PUMP_MSB:`PUMP_LSB];
      filter_series_res_sel <= LOOP_RST[`SRES_MSB:`SRES_LSB];
      filter_parallel_cap_sel <= LOOP_RST[`PCAP_MSB:`PCAP_LSB];
      second_pole_sel <= LOOP_RST[`POLE_BIT];
      lock_accuracy_sel <= MODE_RST[`ACCUR_BIT];
      lock_override_sel <= MODE_RST[`OVRD_BIT];
      manual_osc_choice <= CODE_A_RST[`CHOICE_BIT];
      manual_code_osc_a <= CODE_A_RST[`CODE_MSB:`CODE_LSB];
      manual_code_osc_b <= CODE_B_RST[`CODE_MSB:`CODE_LSB];
      synth_only_sel <= MODE_RST[`SYNTH_BIT];
    end else if (ce) begin
      pump_current_sel <= loop_q[`PUMP_MSB:`PUMP_LSB];
      filter_series_res_sel <= loop_q[`SRES_MSB:`SRES_LSB];
      filter_parallel_cap_sel <= loop_q[`PCAP_MSB:`PCAP_LSB];
      second_pole_sel <= loop_q[`POLE_BIT];
      lock_accuracy_sel <= mode_q[`ACCUR_BIT];
      lock_override_sel <= mode_q[`OVRD_BIT];
      manual_osc_choice <= code_a_q[`CHOICE_BIT];
      manual_code_osc_a <= code_a_q[`CODE_MSB:`CODE_LSB];
      manual_code_osc_b <= code_b_q[`CODE_MSB:`CODE_LSB];
      synth_only_sel <= mode_q[`SYNTH_BIT];
    end
  end

  // The manual code only reaches the loop while override is set, and
  // only the chosen oscillator's code; automatic mode drives zero.
  always @* begin
    applied_nxt = 5'h00;
    if (mode_q[`OVRD_BIT]) begin
      if (code_a_q[`CHOICE_BIT]) begin
        applied_nxt = code_a_q[`CODE_MSB:`CODE_LSB];
      end else begin
        applied_nxt = code_b_q[`CODE_MSB:`CODE_LSB];
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      manual_active_r <= 1'b0;
      osc_a_manual_r <= 1'b0;
      osc_b_manual_r <= 1'b0;
      applied_code_r <= 5'h00;
    end else if (ce) begin
      manual_active_r <= mode_q[`OVRD_BIT];
      osc_a_manual_r <= mode_q[`OVRD_BIT] & code_a_q[`CHOICE_BIT];
      osc_b_manual_r <= mode_q[`OVRD_BIT] & ~code_a_q[`CHOICE_BIT];
      applied_code_r <= applied_nxt;
    end
  end

  // Synthesizer mode needs the companion loop forced to free-run; the
  // bank cannot force it, so it flags any disagreement instead.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      freerun_demand_r <= 1'b0;
      freerun_mismatch_r <= 1'b0;
    end else if (ce) begin
      freerun_demand_r <= mode_q[`SYNTH_BIT];
      freerun_mismatch_r <= mode_q[`SYNTH_BIT] &
        (digital_loop_state != `STATE_FREERUN);
    end
  end

  // Change pulses: only a write that really alters a field counts, so
  // repeated identical writes do not disturb the analog loop.
  always @* begin
    retune_nxt = wr_loop & ((reg_wdata & wr_mask) != wr_old);
    restart_nxt = (wr_mode | wr_code_a | wr_code_b) &
      ((reg_wdata & wr_mask) != wr_old);
    rsvd_nxt = reg_wr & addr_hit & ((reg_wdata & ~wr_mask) != 8'h00);
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loop_retune_r <= 1'b0;
      lock_restart_r <= 1'b0;
      rsvd_write_r <= 1'b0;
    end else if (ce) begin
      loop_retune_r <= retune_nxt;
      lock_restart_r <= restart_nxt;
      rsvd_write_r <= rsvd_nxt;
    end
  end

  // Read path; reserved bits hold zero, unmapped reads return zero.
  always @* begin
    rd_nxt = 8'h00;
    if (reg_addr == `OFS_LOOP_FILTER) begin
      rd_nxt = loop_q;
    end else if (reg_addr == `OFS_MODE_LOCK) begin
      rd_nxt = mode_q;
    end else if (reg_addr == `OFS_VCO_SEL_CODE_A) begin
      rd_nxt = code_a_q;
    end else if (reg_addr == `OFS_CODE_B) begin
      rd_nxt = code_b_q;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_r <= 8'h00;
      reg_rd_valid_r <= 1'b0;
      reg_hit_r <= 1'b0;
    end else if (ce) begin
      reg_rd_valid_r <= reg_rd;
      reg_hit_r <= (reg_rd | reg_wr) & addr_hit;
      if (reg_rd) begin
        reg_rdata_r <= rd_nxt;
      end
    end
  end

  // Physical values for the analog trim, one cycle behind the codes.
  loop_value_decode u_decode (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .pump_code(loop_q[`PUMP_MSB:`PUMP_LSB]),
    .sres_code(loop_q[`SRES_MSB:`SRES_LSB]),
    .pcap_code(loop_q[`PCAP_MSB:`PCAP_LSB]),
    .pole_code(loop_q[`POLE_BIT]),
    .accur_code(mode_q[`ACCUR_BIT]),
    .pump_current_ua_r(pump_current_ua_r),
    .series_res_ohm_r(series_res_ohm_r),
    .parallel_cap_pf_r(parallel_cap_pf_r),
    .post_res_ohm_r(post_res_ohm_r),
    .post_cap_pf_r(post_cap_pf_r),
    .lock_ppm_r(lock_ppm_r)
  );

endmodule

//--- verification/cfg_bank_properties.sv
`timescale 1ns/1ps
`include "apll_cfg_regs.vh"
module cfg_bank_checker (
  // Clock and reset.
  input wire clk,
  input wire rst_n,
  input wire ce,
  // Register port.
  input wire [15:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata_r,
  input wire reg_rd_valid_r,
  // Field copies and manual drive.
  input wire [2:0] pump_current_sel,
  input wire [1:0] filter_series_res_sel,
  input wire [1:0] filter_parallel_cap_sel,
  input wire second_pole_sel,
  input wire lock_accuracy_sel,
  input wire lock_override_sel,
  input wire manual_osc_choice,
  input wire [4:0] manual_code_osc_a,
  input wire [4:0] manual_code_osc_b,
  input wire synth_only_sel,
  input wire osc_a_manual_r,
  input wire osc_b_manual_r,
  input wire [4:0] applied_code_r,
  input wire [4:0] lock_ppm_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Implemented bits of the addressed register; unmapped reads give zero.
  wire [7:0] rd_mask = reg_addr == `OFS_LOOP_FILTER ? 8'hff :
    reg_addr == `OFS_MODE_LOCK ? 8'h0b :
    reg_addr == `OFS_VCO_SEL_CODE_A ? 8'h3f :
    reg_addr == `OFS_CODE_B ? 8'h1f : 8'h00;
  // Writes taken at this edge, one per register.
  wire wr_b0 = reg_wr && ce && reg_addr == `OFS_LOOP_FILTER;
  wire wr_b1 = reg_wr && ce && reg_addr == `OFS_MODE_LOCK;
  wire wr_b2 = reg_wr && ce && reg_addr == `OFS_VCO_SEL_CODE_A;
  wire wr_b3 = reg_wr && ce && reg_addr == `OFS_CODE_B;

  a_pump_field: assert property (wr_b0 ##1 ce |=>
    pump_current_sel == $past(reg_wdata[7:5], 2))
    else $error("Pump field did not follow its write.");
  a_filter_fields: assert property (wr_b0 ##1 ce |=>
    filter_series_res_sel == $past(reg_wdata[4:3], 2) &&
    filter_parallel_cap_sel == $past(reg_wdata[2:1], 2) &&
    second_pole_sel == $past(reg_wdata[0], 2))
    else $error("Filter fields did not follow their write.");
  a_accuracy_field: assert property (wr_b1 ##1 ce |=>
    lock_accuracy_sel == $past(reg_wdata[1], 2) &&
    lock_ppm_r == ($past(reg_wdata[1], 2) ? 5'h10 : 5'h01))
    else $error("Lock accuracy did not follow its write.");
  a_override_synth: assert property (wr_b1 ##1 ce |=>
    lock_override_sel == $past(reg_wdata[0], 2) &&
    synth_only_sel == $past(reg_wdata[3], 2))
    else $error("Override or synth bit did not follow its write.");
  a_code_a_field: assert property (wr_b2 ##1 ce |=>
    manual_osc_choice == $past(reg_wdata[5], 2) &&
    manual_code_osc_a == $past(reg_wdata[4:0], 2))
    else $error("First oscillator code did not follow its write.");
  a_code_b_field: assert property (wr_b3 ##1 ce |=>
    manual_code_osc_b == $past(reg_wdata[4:0], 2))
    else $error("Second oscillator code did not follow its write.");
  a_manual_route: assert property (
    osc_a_manual_r == (lock_override_sel && manual_osc_choice) &&
    osc_b_manual_r == (lock_override_sel && !manual_osc_choice))
    else $error("Manual oscillator routing is wrong.");
  a_applied_code: assert property (
    applied_code_r == (!lock_override_sel ? 5'h00 :
    manual_osc_choice ? manual_code_osc_a : manual_code_osc_b))
    else $error("Applied manual code is wrong.");
  a_reserved_zero: assert property (reg_rd && ce |=>
    reg_rd_valid_r && (reg_rdata_r & ~$past(rd_mask)) == 8'h00)
    else $error("Read returned reserved bits set.");
  a_reset_defaults: assert property ($rose(rst_n) |->
    pump_current_sel == 3'h4 && filter_series_res_sel == 2'h1 &&
    second_pole_sel && lock_accuracy_sel && !lock_override_sel &&
    manual_osc_choice && manual_code_osc_a == 5'h0b &&
    manual_code_osc_b == 5'h00 && !synth_only_sel)
    else $error("Fields not at defaults after reset.");

  // Main scenarios: manual lock on, second oscillator, unmapped read.
  c_manual_on: cover property (wr_b1 && reg_wdata[0]);
  c_osc_b_manual: cover property (osc_b_manual_r);
  c_unmapped_read: cover property (reg_rd && ce && rd_mask == 8'h00);
endmodule

//--- verification/tb_top.sv
`timescale 1ns/1ps
`include "apll_cfg_regs.vh"
module tb_top;
  reg clk, rst_n, ce, reg_wr, reg_rd;
  reg [15:0] reg_addr;
  reg [7:0] reg_wdata, v;
  reg [1:0] digital_loop_state;
  wire [7:0] reg_rdata_r, post_cap_pf_r, parallel_cap_pf_r;
  wire reg_rd_valid_r, reg_hit_r, rsvd_write_r, second_pole_sel;
  wire lock_accuracy_sel, lock_override_sel, manual_osc_choice;
  wire synth_only_sel, manual_active_r, osc_a_manual_r, osc_b_manual_r;
  wire freerun_demand_r, freerun_mismatch_r, loop_retune_r, lock_restart_r;
  wire [2:0] pump_current_sel;
  wire [1:0] filter_series_res_sel, filter_parallel_cap_sel;
  wire [4:0] manual_code_osc_a, manual_code_osc_b, applied_code_r;
  wire [4:0] lock_ppm_r;
  wire [9:0] pump_current_ua_r;
  wire [10:0] series_res_ohm_r, post_res_ohm_r;
  integer fail_count, tests_run, cycles, i;

  analog_pll_config_bank u_analog_pll_config_bank (
    .clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata_r(reg_rdata_r), .reg_rd_valid_r(reg_rd_valid_r),
    .reg_hit_r(reg_hit_r), .rsvd_write_r(rsvd_write_r),
    .digital_loop_state(digital_loop_state),
    .pump_current_sel(pump_current_sel),
    .filter_series_res_sel(filter_series_res_sel),
    .filter_parallel_cap_sel(filter_parallel_cap_sel),
    .second_pole_sel(second_pole_sel), .lock_accuracy_sel(lock_accuracy_sel),
    .lock_override_sel(lock_override_sel),
    .manual_osc_choice(manual_osc_choice),
    .manual_code_osc_a(manual_code_osc_a),
    .manual_code_osc_b(manual_code_osc_b), .synth_only_sel(synth_only_sel),
    .manual_active_r(manual_active_r), .osc_a_manual_r(osc_a_manual_r),
    .osc_b_manual_r(osc_b_manual_r), .applied_code_r(applied_code_r),
    .freerun_demand_r(freerun_demand_r),
    .freerun_mismatch_r(freerun_mismatch_r),
    .loop_retune_r(loop_retune_r), .lock_restart_r(lock_restart_r),
    .pump_current_ua_r(pump_current_ua_r),
    .series_res_ohm_r(series_res_ohm_r),
    .parallel_cap_pf_r(parallel_cap_pf_r), .post_res_ohm_r(post_res_ohm_r),
    .post_cap_pf_r(post_cap_pf_r), .lock_ppm_r(lock_ppm_r)
  );

  // Free-running 250 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task tally_and_finish;
    begin
      if (fail_count == 0 && tests_run > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  task check(input string name, input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("Error %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask

  // One access; returns just after the taking edge, when pulses stand.
  task xfer(input w, input r, input [15:0] a, input [7:0] d);
    begin
      @(posedge clk);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1;
    end
  endtask

  task rd(input [15:0] a, input [7:0] exp, input h);
    begin
      xfer(1'b0, 1'b1, a, 8'h00);
      check("rdata", reg_rdata_r, exp);
      check("rd_valid", reg_rd_valid_r, 1);
      check("hit", reg_hit_r, h);
    end
  endtask

  // Field copies lag the stored value; two edges covers the lag.
  task settle;
    begin
      repeat (2) @(posedge clk);
      #1;
    end
  endtask

  task check_defaults;
    begin
      check("fields", {pump_current_sel, filter_series_res_sel,
        filter_parallel_cap_sel, second_pole_sel, lock_accuracy_sel,
        lock_override_sel, manual_osc_choice, synth_only_sel}, 12'h8ba);
      check("codes", {manual_code_osc_a, manual_code_osc_b,
        applied_code_r}, 15'h2c00);
      check("ua_ohm", {pump_current_ua_r, series_res_ohm_r},
        {10'd550, 11'd640});
      check("pf_post", {parallel_cap_pf_r, post_res_ohm_r,
        lock_ppm_r}, {8'd80, 11'd1580, 5'd16});
      rd(`OFS_LOOP_FILTER, 8'h8b, 1'b1);
      rd(`OFS_MODE_LOCK, 8'h02, 1'b1);
      rd(`OFS_VCO_SEL_CODE_A, 8'h2b, 1'b1);
      rd(`OFS_CODE_B, 8'h00, 1'b1);
    end
  endtask

  // Hang guard, well above the length of the sequence.
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      fail_count = fail_count + 1;
      tally_and_finish;
    end
  end

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    digital_loop_state = 2'h0;
    fail_count = 0;
    tests_run = 0;
    cycles = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    check_defaults;
    // Every code of every loop filter field, read back and decoded.
    for (i = 0; i < 8; i = i + 1) begin
      v = {i[2:0], i[1:0], ~i[1:0], i[0]};
      xfer(1'b1, 1'b0, `OFS_LOOP_FILTER, v);
      check("retune", loop_retune_r, 1);
      settle;
      check("pump", pump_current_sel, i);
      check("pump_ua", pump_current_ua_r, 110 * (i + 1));
      check("sres", series_res_ohm_r, i % 4 == 0 ? 330 :
        i % 4 == 1 ? 640 : i % 4 == 2 ? 1200 : 1790);
      check("pcap", parallel_cap_pf_r, i % 4 == 0 ? 200 :
        i % 4 == 1 ? 140 : i % 4 == 2 ? 80 : 40);
      check("post", {post_res_ohm_r, post_cap_pf_r},
        {i[0] ? 11'd1580 : 11'd497, 8'd40});
      rd(`OFS_LOOP_FILTER, v, 1'b1);
    end
    xfer(1'b1, 1'b0, `OFS_LOOP_FILTER, v);
    check("retune_same", loop_retune_r, 0);
    // Reserved bits dropped; synth mode flags a missing free-run state.
    xfer(1'b1, 1'b0, `OFS_MODE_LOCK, 8'hff);
    check("rsvd_write", rsvd_write_r, 1);
    settle;
    rd(`OFS_MODE_LOCK, 8'h0b, 1'b1);
    check("mode_on", {synth_only_sel, lock_accuracy_sel,
      lock_ppm_r, freerun_demand_r, freerun_mismatch_r}, 9'h1c3);
    @(posedge clk);
    digital_loop_state <= `STATE_FREERUN;
    settle;
    check("mismatch", freerun_mismatch_r, 0);
    xfer(1'b1, 1'b0, `OFS_MODE_LOCK, 8'h00);
    check("rsvd_clean", rsvd_write_r, 0);
    settle;
    check("mode_off", {synth_only_sel, lock_accuracy_sel,
      lock_override_sel, lock_ppm_r}, 8'h01);
    // Manual codes apply only under override, per chosen oscillator.
    xfer(1'b1, 1'b0, `OFS_VCO_SEL_CODE_A, 8'h2f);
    xfer(1'b1, 1'b0, `OFS_CODE_B, 8'h0a);
    check("restart", lock_restart_r, 1);
    settle;
    check("auto", {applied_code_r, manual_code_osc_b}, 10'h00a);
    xfer(1'b1, 1'b0, `OFS_MODE_LOCK, 8'h01);
    settle;
    check("man_a", {applied_code_r, osc_a_manual_r,
      manual_active_r}, 7'h3f);
    xfer(1'b1, 1'b0, `OFS_VCO_SEL_CODE_A, 8'h0f);
    settle;
    check("man_b", {applied_code_r, osc_b_manual_r}, 6'h15);
    rd(`OFS_VCO_SEL_CODE_A, 8'h0f, 1'b1);
    // Unmapped places, including a high-byte alias, are refused.
    xfer(1'b1, 1'b0, 16'h00b4, 8'h55);
    check("wr_hit", reg_hit_r, 0);
    rd(16'h00b4, 8'h00, 1'b0);
    rd(16'h01b0, 8'h00, 1'b0);
    // Read and write together: the read sees the old value.
    xfer(1'b1, 1'b1, `OFS_CODE_B, 8'h15);
    check("old_val", reg_rdata_r, 8'h0a);
    rd(`OFS_CODE_B, 8'h15, 1'b1);
    // With the clock enable low a write must be neither taken nor answered.
    @(posedge clk);
    ce <= 1'b0;
    xfer(1'b1, 1'b0, `OFS_CODE_B, 8'h1f);
    check("frozen_hit", reg_hit_r, 0);
    @(posedge clk);
    ce <= 1'b1;
    rd(`OFS_CODE_B, 8'h15, 1'b1);
    // Reset in mid-run restores every default.
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    check_defaults;
    tally_and_finish;
  end
endmodule

bind analog_pll_config_bank cfg_bank_checker u_cfg_bank_checker (
  .clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata_r(reg_rdata_r), .reg_rd_valid_r(reg_rd_valid_r),
  .pump_current_sel(pump_current_sel),
  .filter_series_res_sel(filter_series_res_sel),
  .filter_parallel_cap_sel(filter_parallel_cap_sel),
  .second_pole_sel(second_pole_sel), .lock_accuracy_sel(lock_accuracy_sel),
  .lock_override_sel(lock_override_sel),
  .manual_osc_choice(manual_osc_choice),
  .manual_code_osc_a(manual_code_osc_a),
  .manual_code_osc_b(manual_code_osc_b), .synth_only_sel(synth_only_sel),
  .osc_a_manual_r(osc_a_manual_r), .osc_b_manual_r(osc_b_manual_r),
  .applied_code_r(applied_code_r), .lock_ppm_r(lock_ppm_r)
);
